// *** shared/ctrl_port_defs.vh ***
`ifndef CTRL_PORT_DEFS_VH
`define CTRL_PORT_DEFS_VH

// Control port register offsets (byte address within the selected port)
`define CP_OFS_SOFT_RESET      8'h00
`define CP_OFS_ERASE_TRIGGER   8'h04
`define CP_OFS_ERASE_STATE     8'h08
`define CP_OFS_PROT_STATE      8'h0C
`define CP_OFS_IDENTITY        8'hFC

// Field positions and reset values
`define CP_SOFT_RESET_BIT      0
`define CP_ERASE_BIT           0
`define CP_SOFT_RESET_RST      1'h0
`define CP_ERASE_IDLE_VALUE    1'h0

// Debug port register selects, address bits [3:2]
`define DP_SEL_ID_ABORT        2'h0
`define DP_SEL_CTRL_STAT       2'h1
`define DP_SEL_SELECT          2'h2
`define DP_SEL_RDBUFF          2'h3

// Power-up request bits of the debug port status word
`define DP_SYS_PWR_REQ_BIT     30
`define DP_DBG_PWR_REQ_BIT     28

// Three-bit link answers, sent least significant bit first
`define LINK_ACK_OK            3'h1
`define LINK_ACK_FAULT         3'h4

// Count of consecutive high data bits that forms a line reset
`define LINK_RESET_ONES        6'h32

// Region strobes of the mass erase sequence
`define ERASE_REGIONS          3

`endif

// *** design/mass_erase_seq.v ***
`timescale 1ns/1ps
`include "ctrl_port_defs.vh"

// Walks flash, user configuration area and RAM one region at a time
module mass_erase_seq #(
	parameter REGIONS = `ERASE_REGIONS
) (
	input  wire               clk_in,
	input  wire               rst_in,
	input  wire               start_in,
	input  wire               region_done_in,
	output reg  [REGIONS-1:0] region_out,
	output reg                busy_out,
	output reg                done_out
);

	reg [REGIONS-1:0] region_next;
	reg               busy_next;
	reg               done_next;

	// One-hot region pointer; start ignored while busy
	always @* begin
		region_next = region_out;
		busy_next   = busy_out;
		done_next   = 1'b0;
		if (!busy_out) begin
			if (start_in) begin
				region_next = {{(REGIONS-1){1'b0}}, 1'b1};
				busy_next   = 1'b1;
			end
		end else if (region_done_in) begin
			// Shift on to the next region, finish after the last
			region_next = {region_out[REGIONS-2:0], 1'b0};
			if (region_out[REGIONS-1]) begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			region_out <= {REGIONS{1'b0}};
			busy_out   <= 1'b0;
			done_out   <= 1'b0;
		end else begin
			region_out <= region_next;
			busy_out   <= busy_next;
			done_out   <= done_next;
		end
	end

endmodule // mass_erase_seq

// *** design/debug_control_port.v ***
// Function
// RL1: Control port stays reachable under protection
// RL2: Protection refuses memory port reads and writes
// RL3: Mass erase command is the only unlock
// RL4: Erase covers flash, configuration area, RAM
// RL5: Soft reset field holds device reset
// RL6: Writing one starts erase, zero ignored
// RL7: Erase state reads one while busy
// RL8: Protection state reads zero when protected
// RL9: Debugger requests power-up before port access
// RL10: After erase, ready and unprotected until reprogrammed
// RL11: Debugger polls erase state until ready
`timescale 1ns/1ps
`include "ctrl_port_defs.vh"

module debug_control_port #(
	parameter [31:0] LINK_IDCODE   = 32'h0000_0001, // Arbitrary value
	parameter [31:0] PORT_IDENTITY = 32'h0000_0A5A, // Arbitrary value
	parameter [7:0]  CTRL_PORT_SEL = 8'h01,
	parameter [7:0]  MEM_PORT_SEL  = 8'h00
) (
	input  wire        CLK_IN,
	input  wire        SYS_RST_IN,
	input  wire        SWDCLK_IN,
	input  wire        SWDIO_IN,
	output reg         SWDIO_OUT,
	output reg         SWDIO_OE_OUT,
	input  wire        PROT_CFG_IN,
	output wire        PROTECTED_OUT,
	output reg         SOFT_RESET_OUT,
	output wire [2:0]  ERASE_REGION_OUT,
	input  wire        ERASE_REGION_DONE_IN,
	output reg         MEM_REQ_OUT,
	output reg         MEM_WRITE_OUT,
	output reg  [7:0]  MEM_ADDR_OUT,
	output reg  [31:0] MEM_WDATA_OUT,
	input  wire [31:0] MEM_RDATA_IN
);

	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_HDR   = 3'h1;
	localparam [2:0] ST_TRN1  = 3'h2;
	localparam [2:0] ST_ACK   = 3'h3;
	localparam [2:0] ST_RDATA = 3'h4;
	localparam [2:0] ST_TRN2  = 3'h5;
	localparam [2:0] ST_WDATA = 3'h6;

	// Link pins cross into the core clock through two flops each
	reg        clk_s1_reg;
	reg        clk_s2_reg;
	reg        clk_s3_reg;
	reg        dio_s1_reg;
	reg        dio_s2_reg;
	wire       link_rise;

	reg [2:0]  state_reg;
	reg [5:0]  cnt_reg;
	reg [5:0]  ones_reg;
	reg [7:0]  hdr_reg;
	reg        ap_reg;
	reg        rnw_reg;
	reg [1:0]  a_reg;
	reg [2:0]  ack_reg;
	reg [31:0] shift_reg;
	reg        par_reg;

	reg [31:0] ctrl_stat_reg;
	reg [7:0]  apsel_reg;
	reg [3:0]  bank_reg;
	reg        unlock_reg;
	reg        prot_prev_reg;

	wire [7:0] hdr_full;
	wire       hdr_ok;
	wire       powered;
	wire       prot_active;
	wire [7:0] ap_addr;
	wire       erase_busy;
	wire       erase_done;
	reg        erase_start;
	reg [2:0]  ack_calc;
	reg [31:0] rdata_calc;

	// Synchronisers and rising edge of the link clock
	always @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			clk_s1_reg <= 1'b0;
			clk_s2_reg <= 1'b0;
			clk_s3_reg <= 1'b0;
			dio_s1_reg <= 1'b1;
			dio_s2_reg <= 1'b1;
		end else begin
			clk_s1_reg <= SWDCLK_IN;
			clk_s2_reg <= clk_s1_reg;
			clk_s3_reg <= clk_s2_reg;
			dio_s1_reg <= SWDIO_IN;
			dio_s2_reg <= dio_s1_reg;
		end
	end

	assign link_rise = clk_s2_reg & ~clk_s3_reg;

	// Header: start, port/debug, read, A2, A3, parity, stop, park
	assign hdr_full = {dio_s2_reg, hdr_reg[7:1]};
	assign hdr_ok   = hdr_full[0] & ~hdr_full[6] & hdr_full[7] &
	                  (hdr_full[5] == ^hdr_full[4:1]);
	assign ap_addr  = {bank_reg, a_reg, 2'b00};

	// Port accesses need both power-up requests set
	assign powered  = ctrl_stat_reg[`DP_SYS_PWR_REQ_BIT] &
	                  ctrl_stat_reg[`DP_DBG_PWR_REQ_BIT]; // RL9
	// Configuration protects until an erase unlocks it
	assign prot_active   = PROT_CFG_IN & ~unlock_reg; // RL3
	assign PROTECTED_OUT = prot_active;

	// Answer to the current request
	always @* begin
		ack_calc = `LINK_ACK_OK;
		if (ap_reg && !powered)
			ack_calc = `LINK_ACK_FAULT;
		else if (ap_reg && apsel_reg == MEM_PORT_SEL && prot_active)
			ack_calc = `LINK_ACK_FAULT; // RL2
	end

	// Read data; the control port ignores protection except in its protection state field
	always @* begin
		rdata_calc = 32'h0000_0000;
		if (!ap_reg) begin
			case (a_reg)
				`DP_SEL_ID_ABORT:  rdata_calc = LINK_IDCODE;
				`DP_SEL_CTRL_STAT: rdata_calc = ctrl_stat_reg;
				default:           rdata_calc = 32'h0000_0000;
			endcase
		end else if (apsel_reg == CTRL_PORT_SEL) begin // RL1
			case (ap_addr)
				`CP_OFS_SOFT_RESET: rdata_calc = {31'h0, SOFT_RESET_OUT};
				`CP_OFS_ERASE_STATE: rdata_calc = {31'h0, erase_busy}; // RL7
				`CP_OFS_PROT_STATE: rdata_calc = {31'h0, ~prot_active}; // RL8
				`CP_OFS_IDENTITY: rdata_calc = PORT_IDENTITY;
				default: rdata_calc = 32'h0000_0000;
			endcase
		end else if (apsel_reg == MEM_PORT_SEL) begin
			rdata_calc = MEM_RDATA_IN;
		end
	end

	// Serial engine, stepped on each link clock rising edge
	always @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			state_reg      <= ST_IDLE;
			cnt_reg        <= 6'h00;
			ones_reg       <= 6'h00;
			hdr_reg        <= 8'h00;
			ap_reg         <= 1'b0;
			rnw_reg        <= 1'b0;
			a_reg          <= 2'h0;
			ack_reg        <= `LINK_ACK_OK;
			shift_reg      <= 32'h0000_0000;
			par_reg        <= 1'b0;
			SWDIO_OUT      <= 1'b1;
			SWDIO_OE_OUT   <= 1'b0;
			ctrl_stat_reg  <= 32'h0000_0000;
			apsel_reg      <= 8'h00;
			bank_reg       <= 4'h0;
			SOFT_RESET_OUT <= `CP_SOFT_RESET_RST; // RL5
			erase_start    <= 1'b0;
			MEM_REQ_OUT    <= 1'b0;
			MEM_WRITE_OUT  <= 1'b0;
			MEM_ADDR_OUT   <= 8'h00;
			MEM_WDATA_OUT  <= 32'h0000_0000;
		end else begin
			erase_start <= 1'b0;
			MEM_REQ_OUT <= 1'b0;
			if (link_rise) begin
				// Long run of ones is a line reset
				if (dio_s2_reg && !SWDIO_OE_OUT && ones_reg != `LINK_RESET_ONES)
					ones_reg <= ones_reg + 6'h01;
				else if (!dio_s2_reg)
					ones_reg <= 6'h00;
				case (state_reg)
					ST_IDLE: begin
						hdr_reg <= {dio_s2_reg, hdr_reg[7:1]};
						cnt_reg <= 6'h01;
						if (dio_s2_reg && ones_reg != `LINK_RESET_ONES)
							state_reg <= ST_HDR;
					end
					ST_HDR: begin
						hdr_reg <= hdr_full;
						cnt_reg <= cnt_reg + 6'h01;
						if (cnt_reg == 6'h07) begin
							ap_reg    <= hdr_full[1];
							rnw_reg   <= hdr_full[2];
							a_reg     <= hdr_full[4:3];
							// Bad header: stay silent, host will retry
							state_reg <= hdr_ok ? ST_TRN1 : ST_IDLE;
						end
					end
					ST_TRN1: begin
						ack_reg      <= ack_calc;
						shift_reg    <= rdata_calc;
						par_reg      <= ^rdata_calc;
						SWDIO_OE_OUT <= 1'b1;
						SWDIO_OUT    <= ack_calc[0];
						cnt_reg      <= 6'h01;
						state_reg    <= ST_ACK;
						// Memory port read strobe only when allowed
						if (ap_reg && rnw_reg && apsel_reg == MEM_PORT_SEL &&
						    ack_calc == `LINK_ACK_OK) begin
							MEM_REQ_OUT   <= 1'b1;
							MEM_WRITE_OUT <= 1'b0;
							MEM_ADDR_OUT  <= ap_addr;
						end
					end
					ST_ACK: begin
						if (cnt_reg != 6'h03) begin
							SWDIO_OUT <= ack_reg[cnt_reg[1:0]];
							cnt_reg   <= cnt_reg + 6'h01;
						end else if (ack_reg == `LINK_ACK_OK && rnw_reg) begin
							SWDIO_OUT <= shift_reg[0];
							shift_reg <= {1'b0, shift_reg[31:1]};
							cnt_reg   <= 6'h01;
							state_reg <= ST_RDATA;
						end else begin
							// Turnaround before write data or after refusal
							SWDIO_OE_OUT <= 1'b0;
							cnt_reg      <= 6'h00;
							state_reg    <= (ack_reg == `LINK_ACK_OK) ? ST_WDATA : ST_TRN2;
						end
					end
					ST_RDATA: begin
						cnt_reg <= cnt_reg + 6'h01;
						if (cnt_reg < 6'h20) begin
							SWDIO_OUT <= shift_reg[0];
							shift_reg <= {1'b0, shift_reg[31:1]};
						end else if (cnt_reg == 6'h20) begin
							SWDIO_OUT <= par_reg;
						end else begin
							SWDIO_OE_OUT <= 1'b0;
							state_reg    <= ST_TRN2;
						end
					end
					ST_TRN2: begin
						// Skip the turnaround bit, the pull-up reads as one
						state_reg <= ST_IDLE;
					end
					ST_WDATA: begin
						cnt_reg <= cnt_reg + 6'h01;
						if (cnt_reg < 6'h20) begin
							shift_reg <= {dio_s2_reg, shift_reg[31:1]};
						end else begin
							state_reg <= ST_IDLE;
							// Writes with bad parity are dropped
							if (dio_s2_reg == ^shift_reg) begin
								if (!ap_reg) begin
									if (a_reg == `DP_SEL_CTRL_STAT)
										ctrl_stat_reg <= shift_reg;
									else if (a_reg == `DP_SEL_SELECT) begin
										apsel_reg <= shift_reg[31:24];
										bank_reg  <= shift_reg[7:4];
									end
								end else if (apsel_reg == CTRL_PORT_SEL) begin
									if (ap_addr == `CP_OFS_SOFT_RESET)
										SOFT_RESET_OUT <= shift_reg[`CP_SOFT_RESET_BIT]; // RL5
									// Zero is the idle value and does nothing
									if (ap_addr == `CP_OFS_ERASE_TRIGGER &&
									    shift_reg[`CP_ERASE_BIT] != `CP_ERASE_IDLE_VALUE)
										erase_start <= 1'b1; // RL6
								end else if (apsel_reg == MEM_PORT_SEL) begin
									MEM_REQ_OUT   <= 1'b1; // RL2
									MEM_WRITE_OUT <= 1'b1;
									MEM_ADDR_OUT  <= ap_addr;
									MEM_WDATA_OUT <= shift_reg;
								end
							end
						end
					end
					default: begin
						state_reg    <= ST_IDLE;
						SWDIO_OE_OUT <= 1'b0;
					end
				endcase
				// Line reset wins over any transfer in flight
				if (dio_s2_reg && !SWDIO_OE_OUT && ones_reg == `LINK_RESET_ONES - 6'h01)
					state_reg <= ST_IDLE;
			end
		end
	end

	// Unlock latch: erase done sets, reprogrammed configuration clears
	always @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			unlock_reg    <= 1'b0;
			prot_prev_reg <= 1'b0;
		end else begin
			prot_prev_reg <= PROT_CFG_IN;
			if (erase_done)
				unlock_reg <= 1'b1; // RL10
			else if (PROT_CFG_IN && !prot_prev_reg)
				unlock_reg <= 1'b0; // RL10
		end
	end

	// Erase sequence over flash, configuration area and RAM
	mass_erase_seq #(
		.REGIONS (`ERASE_REGIONS)
	) u_erase (
		.clk_in         (CLK_IN),
		.rst_in         (SYS_RST_IN),
		.start_in       (erase_start), // RL4
		.region_done_in (ERASE_REGION_DONE_IN),
		.region_out     (ERASE_REGION_OUT),
		.busy_out       (erase_busy),
		.done_out       (erase_done)
	);

endmodule // debug_control_port

// *** sim/ctrl_port_asserts.sv ***
`timescale 1ns/1ps
module ctrl_port_asserts (
	input wire logic       CLK_IN,
	input wire logic       SYS_RST_IN,
	input wire logic       PROT_CFG_IN,
	input wire logic       PROTECTED_OUT,
	input wire logic       SOFT_RESET_OUT,
	input wire logic       SWDIO_OE_OUT,
	input wire logic [2:0] ERASE_REGION_OUT,
	input wire logic       ERASE_REGION_DONE_IN,
	input wire logic       MEM_REQ_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);

	// Last region done, then idle, then the lock drops
	sequence ram_done_s;
		ERASE_REGION_OUT == 3'h4 && ERASE_REGION_DONE_IN;
	endsequence
	sequence unlock_s;
		ERASE_REGION_OUT == 3'h0 ##1 !PROTECTED_OUT;
	endsequence

	// Nothing held, driven or erasing straight after reset
	reset_clear_a: assert property ($past(SYS_RST_IN) |-> !SWDIO_OE_OUT && !SOFT_RESET_OUT
		&& ERASE_REGION_OUT == 3'h0) else $error("outputs active after reset");
	mem_lock_a: assert property (PROTECTED_OUT |-> !MEM_REQ_OUT)
		else $error("memory access while protected");
	region_onehot_a: assert property ($onehot0(ERASE_REGION_OUT))
		else $error("more than one erase region");
	region_start_a: assert property ($rose(ERASE_REGION_OUT != 3'h0)
		|-> ERASE_REGION_OUT == 3'h1) else $error("erase did not start with flash");
	flash_next_a: assert property (ERASE_REGION_OUT == 3'h1 && ERASE_REGION_DONE_IN
		|=> ERASE_REGION_OUT == 3'h2) else $error("config area not next");
	config_next_a: assert property (ERASE_REGION_OUT == 3'h2 && ERASE_REGION_DONE_IN
		|=> ERASE_REGION_OUT == 3'h4) else $error("RAM not next");
	erase_unlock_a: assert property (ram_done_s |=> unlock_s)
		else $error("no unlock after erase");
	relock_a: assert property ($rose(PROT_CFG_IN) |=> PROTECTED_OUT)
		else $error("reprogramming did not relock");
endmodule // ctrl_port_asserts

// *** sim/swd_debugger.sv ***
`timescale 1ns/1ps
`include "ctrl_port_defs.vh"
module swd_debugger (
	output logic swclk_out,
	output wire  line_out,
	input  wire  dev_data_in,
	input  wire  dev_oe_in
);
	logic drv = 1'h0;
	logic val = 1'h1;
	// Set by a scenario to send a wrong write parity bit
	logic par_flip = 1'h0;

	// Pull-up wins when nobody drives the data line
	assign line_out = dev_oe_in ? dev_data_in : (drv ? val : 1'h1);
	initial swclk_out = 1'h0;

	// One bit: drive in the low phase, sample at the falling edge
	task automatic bitc(input logic d, input logic en, output logic s);
		drv = en;
		val = d;
		#40 swclk_out = 1'h1;
		#40 s = line_out;
		swclk_out = 1'h0;
	endtask

	// Header, answer, data phase; clock stops low after the idle bit
	task automatic xfer(input logic ap, rnw, input logic [1:0] a, input logic [31:0] wd,
		output logic [2:0] ack, output logic [31:0] rd, output logic rp);
		logic s;
		logic [7:0] h;
		h = {1'h1, 1'h0, ^{ap, rnw, a}, a[1], a[0], rnw, ap, 1'h1};
		rd = 32'h0;
		rp = 1'h0;
		for (int i = 0; i < 8; i++) bitc(h[i], 1'h1, s);
		for (int i = 0; i < 3; i++) bitc(1'h1, 1'h0, ack[i]);
		if (ack == `LINK_ACK_OK && rnw) begin
			for (int i = 0; i < 32; i++) bitc(1'h1, 1'h0, rd[i]);
			bitc(1'h1, 1'h0, rp);
			repeat (2) bitc(1'h1, 1'h0, s);
		end else if (ack == `LINK_ACK_OK) begin
			bitc(1'h1, 1'h0, s);
			for (int i = 0; i < 32; i++) bitc(wd[i], 1'h1, s);
			bitc(^wd ^ par_flip, 1'h1, s);
		end else
			repeat (2) bitc(1'h1, 1'h0, s);
		bitc(1'h0, 1'h1, s);
	endtask
endmodule // swd_debugger

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`include "ctrl_port_defs.vh"
module testbench;
	localparam [31:0] IDENT    = 32'h0000_0A5A; // Arbitrary value
	localparam [31:0] LINK_ID  = 32'h0000_0C35; // Arbitrary value
	localparam [31:0] MEM_WORD = 32'hC3A5_0F96;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic        prot_cfg = 1'h1;
	logic        region_done = 1'h0;
	wire         swclk, line, dout, oe, protd, srst, mreq, mwr;
	wire  [2:0]  region;
	wire  [7:0]  maddr;
	wire  [31:0] mwdata;
	logic [2:0]  ack;
	logic [31:0] rd, seen_wd = 32'h0;
	logic [7:0]  seen_addr = 8'h0;
	logic        rp, seen_wr = 1'h0;
	int          n_errors = 0;
	int          num_checks = 0;

	always #2 clk = ~clk;

	debug_control_port #(.LINK_IDCODE(LINK_ID), .PORT_IDENTITY(IDENT)) debug_control_port_i (
		.CLK_IN(clk), .SYS_RST_IN(rst), .SWDCLK_IN(swclk), .SWDIO_IN(line),
		.SWDIO_OUT(dout), .SWDIO_OE_OUT(oe), .PROT_CFG_IN(prot_cfg), .PROTECTED_OUT(protd),
		.SOFT_RESET_OUT(srst), .ERASE_REGION_OUT(region), .ERASE_REGION_DONE_IN(region_done),
		.MEM_REQ_OUT(mreq), .MEM_WRITE_OUT(mwr), .MEM_ADDR_OUT(maddr),
		.MEM_WDATA_OUT(mwdata), .MEM_RDATA_IN(MEM_WORD));
	swd_debugger swd_debugger_i (.swclk_out(swclk), .line_out(line), .dev_data_in(dout),
		.dev_oe_in(oe));

	// Memory side sees only pulses, so keep the last request
	always @(posedge clk) if (mreq) begin
		seen_addr <= maddr;
		seen_wr <= mwr;
		seen_wd <= mwdata;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic xf(input logic ap, rnw, input logic [1:0] a, input logic [31:0] wd);
		@(negedge clk);
		swd_debugger_i.xfer(ap, rnw, a, wd, ack, rd, rp);
	endtask
	// Select port and bank, then one port access with its answer checked
	task automatic acc(input logic [7:0] sel, ofs, input logic rnw, input logic [31:0] wd,
		input logic [2:0] exp_ack);
		xf(1'h0, 1'h0, `DP_SEL_SELECT, {sel, 16'h0, ofs[7:4], 4'h0});
		xf(1'h1, rnw, ofs[3:2], wd);
		chk("answer", exp_ack, ack);
	endtask
	task automatic cp_rd(input logic [7:0] ofs, input logic [31:0] exp, input string what);
		acc(8'h01, ofs, 1'h1, 32'h0, `LINK_ACK_OK);
		chk(what, exp, rd);
		chk("parity", ^rd, rp);
	endtask
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Reset state; port access refused until power is requested
	task automatic t_reset();
		chk("soft reset", 32'h0, srst);
		chk("protected", 32'h1, protd);
		chk("regions", 32'h0, region);
		acc(8'h01, `CP_OFS_IDENTITY, 1'h1, 32'h0, `LINK_ACK_FAULT);
		xf(1'h0, 1'h0, `DP_SEL_CTRL_STAT, 32'h5000_0000);
		xf(1'h0, 1'h1, `DP_SEL_CTRL_STAT, 32'h0);
		chk("power bits", 32'h5000_0000, rd);
		// Link identity is read back after the power requests are set
		xf(1'h0, 1'h1, `DP_SEL_ID_ABORT, 32'h0);
		chk("link id answer", `LINK_ACK_OK, ack);
		chk("link id", LINK_ID, rd);
	endtask
	// Locked: memory port refused both ways, control port still answers
	task automatic t_locked();
		acc(8'h00, 8'h14, 1'h1, 32'h0, `LINK_ACK_FAULT);
		acc(8'h00, 8'h14, 1'h0, 32'h1234_5678, `LINK_ACK_FAULT);
		cp_rd(`CP_OFS_IDENTITY, IDENT, "identity");
		cp_rd(`CP_OFS_PROT_STATE, 32'h0, "protection state");
		cp_rd(`CP_OFS_ERASE_STATE, 32'h0, "erase state");
		cp_rd(8'h10, 32'h0, "unmapped");
	endtask
	task automatic t_soft();
		acc(8'h01, `CP_OFS_SOFT_RESET, 1'h0, 32'h1, `LINK_ACK_OK);
		chk("soft reset set", 32'h1, srst);
		cp_rd(`CP_OFS_SOFT_RESET, 32'h1, "soft reset field");
		acc(8'h01, `CP_OFS_SOFT_RESET, 1'h0, 32'h0, `LINK_ACK_OK);
		chk("soft reset clear", 32'h0, srst);
		// Bad parity on the data phase: the write must be dropped
		xf(1'h0, 1'h0, `DP_SEL_SELECT, 32'h0100_0000);
		swd_debugger_i.par_flip = 1'h1;
		xf(1'h1, 1'h0, 2'h0, 32'h1);
		swd_debugger_i.par_flip = 1'h0;
		chk("bad parity answer", `LINK_ACK_OK, ack);
		chk("bad parity dropped", 32'h0, srst);
	endtask
	// Zero ignored, one walks all regions, then unlocked
	task automatic t_erase();
		acc(8'h01, `CP_OFS_ERASE_TRIGGER, 1'h0, 32'h0, `LINK_ACK_OK);
		chk("erase on zero", 32'h0, region);
		acc(8'h01, `CP_OFS_ERASE_TRIGGER, 1'h0, 32'h1, `LINK_ACK_OK);
		cp_rd(`CP_OFS_ERASE_STATE, 32'h1, "erase busy");
		for (int i = 0; i < `ERASE_REGIONS; i++) begin
			// A second start while busy must not restart the walk
			if (i == 1)
				acc(8'h01, `CP_OFS_ERASE_TRIGGER, 1'h0, 32'h1, `LINK_ACK_OK);
			chk("region", 32'h1 << i, region);
			@(negedge clk) region_done = 1'h1;
			@(negedge clk) region_done = 1'h0;
		end
		repeat (4) @(negedge clk);
		chk("unlocked", 32'h0, protd);
		cp_rd(`CP_OFS_ERASE_STATE, 32'h0, "erase ready");
		cp_rd(`CP_OFS_PROT_STATE, 32'h1, "protection off");
	endtask
	task automatic t_mem();
		acc(8'h00, 8'h24, 1'h0, 32'h1234_5678, `LINK_ACK_OK);
		chk("write addr", 32'h24, seen_addr);
		chk("write flag", 32'h1, seen_wr);
		chk("write data", 32'h1234_5678, seen_wd);
		acc(8'h00, 8'h18, 1'h1, 32'h0, `LINK_ACK_OK);
		chk("read data", MEM_WORD, rd);
		chk("read addr", 32'h18, seen_addr);
		chk("read flag", 32'h0, seen_wr);
	endtask
	// Reprogrammed protection locks the memory port again
	task automatic t_relock();
		@(negedge clk) prot_cfg = 1'h0;
		@(negedge clk) prot_cfg = 1'h1;
		repeat (2) @(negedge clk);
		chk("relocked", 32'h1, protd);
		acc(8'h00, 8'h24, 1'h1, 32'h0, `LINK_ACK_FAULT);
		cp_rd(`CP_OFS_PROT_STATE, 32'h0, "protection back");
	endtask

	initial begin
		repeat (3) @(negedge clk);
		rst = 1'h0;
		repeat (3) @(negedge clk);
		t_reset();
		t_locked();
		t_soft();
		t_erase();
		t_mem();
		t_relock();
		complete_run();
	end
endmodule // testbench

bind debug_control_port ctrl_port_asserts ctrl_port_asserts_i (
	.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .PROT_CFG_IN(PROT_CFG_IN),
	.PROTECTED_OUT(PROTECTED_OUT), .SOFT_RESET_OUT(SOFT_RESET_OUT), .SWDIO_OE_OUT(SWDIO_OE_OUT),
	.ERASE_REGION_OUT(ERASE_REGION_OUT), .ERASE_REGION_DONE_IN(ERASE_REGION_DONE_IN),
	.MEM_REQ_OUT(MEM_REQ_OUT));
